// [rtl/sslk_pkg.sv]
// Shared constants for the synchronous serial block link.
// Assumes a 100 MHz system clock on both ends.
package sslk_pkg;
    localparam int WORD_W = 16;
    localparam logic [4:0] WORD_BITS = 5'h10;

    // Host port addresses of the controller end
    localparam logic [15:0] ADDR_CTRL_WR = 16'h7240;
    localparam logic [15:0] ADDR_TX_DATA = 16'h7241;
    localparam logic [15:0] ADDR_STATUS_RD = 16'hF240;
    localparam logic [15:0] ADDR_RX_DATA = 16'hF241;

    // Status bit positions
    localparam int ST_TX_BUSY = 4;
    localparam int ST_TX_ROOM = 3;
    localparam int ST_OVERRUN_N = 2;
    localparam int ST_RX_NONE = 1;
    localparam int ST_INT = 0;

    // Control write values; a zero bit clears the matching flag
    localparam logic [15:0] OVERRUN_CLEAR_VALUE = 16'hFFFB;
    localparam logic [15:0] INT_CLEAR_VALUE = 16'hFFFE;

    // Timing
    localparam int CLK_NS = 10;
    localparam int BIT_NS = 8000;
    localparam int HALF_BIT_CYC = BIT_NS / (2 * CLK_NS);
    localparam int US_CYC = 1000 / CLK_NS;
    localparam int C2P_GAP_US = 2000;
    localparam int P2C_GAP_US = 15000;
    localparam int P2C_GAP_CYC = P2C_GAP_US * US_CYC;
    localparam int RX_WAIT_FACTOR = 2;
    localparam int RX_WAIT_CYC = RX_WAIT_FACTOR * P2C_GAP_CYC;
    localparam int MS_US = 1000;
    localparam int MS_CYC = MS_US * US_CYC;
    localparam int BLK_TIMEOUT_US = 4000;
    localparam int BLK_TIMEOUT_MS = BLK_TIMEOUT_US / MS_US;

    // Block format
    localparam logic [15:0] MAX_LEN_WORD = 16'h0403;
    localparam logic [10:0] MAX_BLOCK_WORDS = 11'h405;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_LEN_MISMATCH = 4'h1;
    localparam logic [3:0] ERR_EXCESS = 4'h2;
    localparam logic [3:0] ERR_LEN_BIG = 4'hB;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SHIFT = 2'b01,
        TX_BLKGAP = 2'b11
    } sslk_tx_t;
endpackage

// [rtl/sslk_if.sv]
// Link wires between the controller end and the processor end.
// The controller makes the link clock; each direction has envelope and data.
`timescale 1ns/100ps
interface sslk_if;
    logic link_clk;
    logic c2p_envelope;
    logic c2p_data;
    logic p2c_envelope;
    logic p2c_data;

    modport ctrl (
        output link_clk,
        output c2p_envelope,
        output c2p_data,
        input p2c_envelope,
        input p2c_data
    );

    modport proc (
        input link_clk,
        input c2p_envelope,
        input c2p_data,
        output p2c_envelope,
        output p2c_data
    );
endinterface

// [rtl/sslk_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Single clock; full and empty derived from an occupancy count.
`timescale 1ns/100ps
module sslk_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_out = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign out_data_out = mem[rd_ptr_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + (AW+1)'(1);
        end else if (pop && !push) begin
            count_r <= count_r - (AW+1)'(1);
        end
    end
endmodule

// [rtl/sslk_ctrl.sv]
// Controller end of the serial block link: link master and host port.
// Assumes host software paces block gaps and drains receive words in time.
//
// Functional notes
// - Controller drives free-running 125 kHz link clock
// - Envelope high exactly while 16 bits shift
// - Word gap one bit minimum, below block gap
// - Idle at least block gap after block
// - Block ends after about twice sender gap
// - Block gap 2 ms outbound, 15 ms inbound
// - Interrupt after first word of block
// - Host reads first word within 136 us
// - Overflow goes low on unread word, sticky
// - Write FFFB clears overflow, then dummy read
// - Write FFFE clears pending link interrupt
// - Status bit 3 gates transmit word writes
// - Receive bit low means word waiting
// - Block is type, length, then payload
// - Length word above 1027 is error
// - Block complete after 4 ms silence
// - Word count must equal length plus two
// - No acknowledge, correction or checksum
// - Distinct error codes per fault kind
// - Reset: clear buffers, write FFFB, FFFE
// - Processor ends block on 1 ms ticks
// - Truncated word raises controller overflow
`timescale 1ns/100ps
module sslk_ctrl
    import sslk_pkg::*;
#(
    parameter int HALF_BIT = HALF_BIT_CYC,
    parameter int RX_WAIT = RX_WAIT_CYC,
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link
    sslk_if.ctrl link,
    // Host port
    input wire logic [15:0] bus_addr_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [15:0] bus_wdata_in,
    output logic [15:0] bus_rdata_out,
    // Link interrupt
    output logic irq_out
);
    logic [15:0] div_r;
    logic lclk_r;
    logic tick;
    logic rise_now;
    logic fall_now;

    // Link clock divider
    assign tick = (div_r == 16'(HALF_BIT - 1));
    assign rise_now = tick && !lclk_r;
    assign fall_now = tick && lclk_r;

    always_ff @(posedge clk_in) begin
        if (reset_in || tick) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            lclk_r <= 1'b0;
        end else if (tick) begin
            lclk_r <= ~lclk_r;
        end
    end

    assign link.link_clk = lclk_r;

    // Host decode
    logic wr_ctrl;
    logic wr_tx;
    logic rd_st;
    logic rd_rx;

    assign wr_ctrl = bus_wr_in && (bus_addr_in == ADDR_CTRL_WR);
    assign wr_tx = bus_wr_in && (bus_addr_in == ADDR_TX_DATA);
    assign rd_st = bus_rd_in && (bus_addr_in == ADDR_STATUS_RD);
    assign rd_rx = bus_rd_in && (bus_addr_in == ADDR_RX_DATA);

    // Transmit path
    logic fifo_room;
    logic fifo_valid;
    logic [WORD_W-1:0] fifo_data;
    logic tx_take;
    sslk_tx_t tx_state_r;
    logic [WORD_W-1:0] tx_sh_r;
    logic [4:0] tx_cnt_r;
    logic tx_env_r;
    logic tx_dat_r;

    // Writes while full are dropped; host must poll the room bit first
    sslk_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_valid_in(wr_tx),
        .in_data_in(bus_wdata_in),
        .in_ready_out(fifo_room),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(tx_take)
    );

    assign tx_take = fall_now && (tx_state_r == TX_IDLE) && fifo_valid;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_state_r <= TX_IDLE;
        end else if (fall_now) begin
            case (tx_state_r)
                TX_IDLE: begin
                    if (fifo_valid) begin
                        tx_state_r <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tx_cnt_r == WORD_BITS) begin
                        tx_state_r <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state_r <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_sh_r <= 16'h0000;
            tx_cnt_r <= 5'h00;
            tx_env_r <= 1'b0;
            tx_dat_r <= 1'b0;
        end else if (fall_now) begin
            if (tx_state_r == TX_IDLE) begin
                tx_env_r <= fifo_valid;
                tx_dat_r <= fifo_valid && fifo_data[WORD_W-1];
                tx_sh_r <= {fifo_data[WORD_W-2:0], 1'b0};
                tx_cnt_r <= 5'h01;
            end else if (tx_cnt_r == WORD_BITS) begin
                tx_env_r <= 1'b0;
                tx_dat_r <= 1'b0;
            end else begin
                tx_dat_r <= tx_sh_r[WORD_W-1];
                tx_sh_r <= {tx_sh_r[WORD_W-2:0], 1'b0};
                tx_cnt_r <= tx_cnt_r + 5'h01;
            end
        end
    end

    assign link.c2p_envelope = tx_env_r;
    assign link.c2p_data = tx_dat_r;

    // Receive path
    logic env_s1;
    logic env_s2;
    logic dat_s1;
    logic dat_s2;
    logic [WORD_W-1:0] rx_sh_r;
    logic [4:0] rx_cnt_r;
    logic word_end;
    logic word_good;
    logic [WORD_W-1:0] rx_data_r;
    logic rx_full_r;
    logic rx_overrun_flag_r;
    logic int_r;
    logic [31:0] idle_cnt_r;
    logic blk_idle_r;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            env_s1 <= 1'b0;
            env_s2 <= 1'b0;
            dat_s1 <= 1'b0;
            dat_s2 <= 1'b0;
        end else begin
            env_s1 <= link.p2c_envelope;
            env_s2 <= env_s1;
            dat_s1 <= link.p2c_data;
            dat_s2 <= dat_s1;
        end
    end

    assign word_end = rise_now && !env_s2 && (rx_cnt_r != 5'h00);
    assign word_good = (rx_cnt_r == WORD_BITS);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_sh_r <= 16'h0000;
            rx_cnt_r <= 5'h00;
        end else if (rise_now) begin
            if (env_s2) begin
                rx_sh_r <= {rx_sh_r[WORD_W-2:0], dat_s2};
                if (rx_cnt_r != 5'h1F) begin
                    rx_cnt_r <= rx_cnt_r + 5'h01;
                end
            end else begin
                rx_cnt_r <= 5'h00;
            end
        end
    end

    // Holding register; a read frees it, a new word in the same cycle wins
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_data_r <= 16'h0000;
            rx_full_r <= 1'b0;
        end else if (word_end && word_good && (!rx_full_r || rd_rx)) begin
            rx_data_r <= rx_sh_r;
            rx_full_r <= 1'b1;
        end else if (rd_rx) begin
            rx_full_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_overrun_flag_r <= 1'b0;
        end else if (word_end && ((rx_full_r && !rd_rx) || !word_good)) begin
            rx_overrun_flag_r <= 1'b1;
        end else if (wr_ctrl && !bus_wdata_in[ST_OVERRUN_N]) begin
            rx_overrun_flag_r <= 1'b0;
        end
    end

    // Silence timer decides which word opens a block
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            idle_cnt_r <= 32'h0000_0000;
            blk_idle_r <= 1'b1;
        end else if (env_s2 || (rx_cnt_r != 5'h00)) begin
            idle_cnt_r <= 32'h0000_0000;
            if (word_end) begin
                blk_idle_r <= 1'b0;
            end
        end else if (idle_cnt_r == 32'(RX_WAIT - 1)) begin
            blk_idle_r <= 1'b1;
        end else begin
            idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            int_r <= 1'b0;
        end else if (word_end && blk_idle_r) begin
            int_r <= 1'b1;
        end else if (wr_ctrl && !bus_wdata_in[ST_INT]) begin
            int_r <= 1'b0;
        end
    end

    assign irq_out = int_r;

    // Read data, one cycle after the read strobe
    logic [15:0] status;
    always_comb begin
        status = 16'h0000;
        status[ST_TX_BUSY] = (tx_state_r != TX_IDLE) || fifo_valid;
        status[ST_TX_ROOM] = fifo_room;
        status[ST_OVERRUN_N] = ~rx_overrun_flag_r;
        status[ST_RX_NONE] = ~rx_full_r;
        status[ST_INT] = int_r;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bus_rdata_out <= 16'h0000;
        end else if (rd_st) begin
            bus_rdata_out <= status;
        end else if (rd_rx) begin
            bus_rdata_out <= rx_data_r;
        end else if (bus_rd_in) begin
            bus_rdata_out <= 16'h0000;
        end
    end
endmodule

// [rtl/sslk_proc.sv]
// Processor end of the serial block link: link slave.
// Link clock arrives from the controller and is sampled on clk_in.
`timescale 1ns/100ps
module sslk_proc
    import sslk_pkg::*;
#(
    parameter int TX_BLK_GAP = P2C_GAP_CYC,
    parameter int MS_TICK = MS_CYC,
    parameter int TIMEOUT_MS = BLK_TIMEOUT_MS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link
    sslk_if.proc link,
    // Transmit words
    input wire logic tx_valid_in,
    input wire logic [15:0] tx_data_in,
    input wire logic tx_last_in,
    output logic tx_ready_out,
    // Received words and block result
    output logic rx_word_valid_out,
    output logic [15:0] rx_word_out,
    output logic block_done_out,
    output logic [3:0] block_err_out
);
    logic lc_s1;
    logic lc_s2;
    logic lc_s3;
    logic env_s1;
    logic env_s2;
    logic dat_s1;
    logic dat_s2;
    logic rise;
    logic fall;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            {lc_s1, lc_s2, lc_s3} <= 3'h0;
            {env_s1, env_s2, dat_s1, dat_s2} <= 4'h0;
        end else begin
            lc_s1 <= link.link_clk;
            lc_s2 <= lc_s1;
            lc_s3 <= lc_s2;
            env_s1 <= link.c2p_envelope;
            env_s2 <= env_s1;
            dat_s1 <= link.c2p_data;
            dat_s2 <= dat_s1;
        end
    end

    assign rise = lc_s2 && !lc_s3;
    assign fall = !lc_s2 && lc_s3;

    // Transmitter
    sslk_tx_t st_r;
    logic [15:0] sh_r;
    logic [4:0] cnt_r;
    logic last_r;
    logic env_r;
    logic dat_r;
    logic [31:0] gap_r;

    assign tx_ready_out = fall && (st_r == TX_IDLE);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_r <= TX_IDLE;
            sh_r <= 16'h0000;
            cnt_r <= 5'h00;
            last_r <= 1'b0;
            env_r <= 1'b0;
            dat_r <= 1'b0;
            gap_r <= 32'h0000_0000;
        end else begin
            case (st_r)
                TX_IDLE: begin
                    if (tx_ready_out && tx_valid_in) begin
                        st_r <= TX_SHIFT;
                        env_r <= 1'b1;
                        dat_r <= tx_data_in[WORD_W-1];
                        sh_r <= {tx_data_in[WORD_W-2:0], 1'b0};
                        cnt_r <= 5'h01;
                        last_r <= tx_last_in;
                    end
                end
                TX_SHIFT: begin
                    if (fall && (cnt_r == WORD_BITS)) begin
                        env_r <= 1'b0;
                        dat_r <= 1'b0;
                        gap_r <= 32'h0000_0000;
                        st_r <= last_r ? TX_BLKGAP : TX_IDLE;
                    end else if (fall) begin
                        dat_r <= sh_r[WORD_W-1];
                        sh_r <= {sh_r[WORD_W-2:0], 1'b0};
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                TX_BLKGAP: begin
                    if (gap_r == 32'(TX_BLK_GAP - 1)) begin
                        st_r <= TX_IDLE;
                    end else begin
                        gap_r <= gap_r + 32'h0000_0001;
                    end
                end
                default: begin
                    st_r <= TX_IDLE;
                end
            endcase
        end
    end

    assign link.p2c_envelope = env_r;
    assign link.p2c_data = dat_r;

    // Receiver, one pulse per word; truncated words are dropped
    logic [15:0] rsh_r;
    logic [4:0] rcnt_r;
    logic word_end;

    assign word_end = rise && !env_s2 && (rcnt_r == WORD_BITS);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rsh_r <= 16'h0000;
            rcnt_r <= 5'h00;
            rx_word_out <= 16'h0000;
            rx_word_valid_out <= 1'b0;
        end else begin
            rx_word_valid_out <= word_end;
            if (word_end) begin
                rx_word_out <= rsh_r;
            end
            if (rise && env_s2) begin
                rsh_r <= {rsh_r[WORD_W-2:0], dat_s2};
                rcnt_r <= (rcnt_r == 5'h1F) ? rcnt_r : rcnt_r + 5'h01;
            end else if (rise) begin
                rcnt_r <= 5'h00;
            end
        end
    end

    // Block timer on 1 ms ticks, restarted by every word
    logic [31:0] ms_r;
    logic [7:0] tmo_r;
    logic [10:0] wcnt_r;
    logic [15:0] len_r;
    logic expire;

    assign expire = (ms_r == 32'(MS_TICK - 1)) && (tmo_r == 8'h01);

    always_ff @(posedge clk_in) begin
        if (reset_in || word_end || ms_r == 32'(MS_TICK - 1)) begin
            ms_r <= 32'h0000_0000;
        end else begin
            ms_r <= ms_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tmo_r <= 8'h00;
        end else if (word_end) begin
            tmo_r <= 8'(TIMEOUT_MS);
        end else if (ms_r == 32'(MS_TICK - 1) && tmo_r != 8'h00) begin
            tmo_r <= tmo_r - 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wcnt_r <= 11'h000;
            len_r <= 16'h0000;
            block_err_out <= ERR_NONE;
            block_done_out <= 1'b0;
        end else begin
            block_done_out <= expire;
            if (word_end) begin
                if (wcnt_r == 11'h000) begin
                    block_err_out <= ERR_NONE;
                end
                if (wcnt_r == 11'h001) begin
                    len_r <= rsh_r;
                    if (rsh_r > MAX_LEN_WORD) begin
                        block_err_out <= ERR_LEN_BIG;
                    end
                end
                if (wcnt_r >= MAX_BLOCK_WORDS) begin
                    block_err_out <= ERR_EXCESS;
                end else begin
                    wcnt_r <= wcnt_r + 11'h001;
                end
            end else if (expire) begin
                wcnt_r <= 11'h000;
                if (block_err_out == ERR_NONE && 16'(wcnt_r) != len_r + 16'h0002) begin
                    block_err_out <= ERR_LEN_MISMATCH;
                end
            end
        end
    end
endmodule

// [bench/sslk_chk.sv]
// Wire-level checks on the link between controller end and processor end.
// Assumes one system clock for both ends and the bench's short half bit.
`timescale 1ns/100ps
module sslk_chk #(
    parameter int HALF_BIT = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link wires
    input wire logic link_clk,
    input wire logic c2p_envelope,
    input wire logic c2p_data,
    input wire logic p2c_envelope,
    input wire logic p2c_data
);
    localparam logic [9:0] ENV_CYC = 10'(32 * HALF_BIT);
    logic [7:0] tog_cnt_r;
    logic seen_r;
    logic [9:0] c2p_cnt_r;
    logic [9:0] p2c_cnt_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // First toggle after reset only arms the half period count
    always_ff @(posedge clk_in) begin
        tog_cnt_r <= (reset_in || $changed(link_clk)) ? 8'h00 : tog_cnt_r + 8'h01;
    end
    always_ff @(posedge clk_in) begin
        seen_r <= reset_in ? 1'b0 : (seen_r || $changed(link_clk));
    end
    always_ff @(posedge clk_in) begin
        c2p_cnt_r <= (reset_in || !c2p_envelope) ? 10'h000 : c2p_cnt_r + 10'h001;
    end
    always_ff @(posedge clk_in) begin
        p2c_cnt_r <= (reset_in || !p2c_envelope) ? 10'h000 : p2c_cnt_r + 10'h001;
    end

    sequence quiet_bit(logic env);
        !env [*8];
    endsequence
    property env_len(logic env, logic [9:0] cnt);
        $fell(env) |-> cnt == ENV_CYC;
    endproperty

    link_toggle_a: assert property (seen_r && $changed(link_clk) |-> tog_cnt_r == 8'(HALF_BIT - 1))
        else $error("link clock half period wrong");
    link_free_a: assert property (seen_r |-> tog_cnt_r < 8'(HALF_BIT))
        else $error("link clock stopped");
    c2p_len_a: assert property (env_len(c2p_envelope, c2p_cnt_r))
        else $error("outbound envelope length wrong");
    p2c_len_a: assert property (env_len(p2c_envelope, p2c_cnt_r))
        else $error("inbound envelope length wrong");
    c2p_gap_a: assert property ($fell(c2p_envelope) |-> quiet_bit(c2p_envelope))
        else $error("outbound word gap too short");
    p2c_gap_a: assert property ($fell(p2c_envelope) |-> quiet_bit(p2c_envelope))
        else $error("inbound word gap too short");
    c2p_bit_a: assert property (c2p_envelope && $changed(c2p_data) |-> !link_clk)
        else $error("outbound data changed in high half");
    c2p_start_a: assert property ($rose(c2p_envelope) |-> !link_clk)
        else $error("outbound envelope not on clock fall");
endmodule

// [bench/sslk_test.sv]
// Bench joining controller end and processor end over the link interface.
// Drives the host port and the processor word ports with a shared clock.
`timescale 1ns/100ps
module sslk_test
    import sslk_pkg::*;
;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [15:0] bus_addr_in = 16'h0000;
    logic bus_wr_in = 1'b0;
    logic bus_rd_in = 1'b0;
    logic [15:0] bus_wdata_in = 16'h0000;
    logic [15:0] bus_rdata_out;
    logic irq_out;
    logic tx_valid_in = 1'b0;
    logic [15:0] tx_data_in = 16'h0000;
    logic tx_last_in = 1'b0;
    logic tx_ready_out;
    logic rx_word_valid_out;
    logic [15:0] rx_word_out;
    logic block_done_out;
    logic [3:0] block_err_out;
    int err_total = 0;
    int num_checks = 0;
    int seed = 11;
    logic [15:0] exp_q[$];
    logic [15:0] v;
    logic [15:0] blk[6];
    logic [15:0] case_len[4] = '{16'h0002, 16'h0005, 16'h0404, 16'h0403};
    int case_pay[4] = '{2, 1, 0, 0};

    sslk_if sslk_if_inst ();
    sslk_ctrl #(.HALF_BIT(4), .RX_WAIT(400)) sslk_ctrl_inst (
        .clk_in, .reset_in, .link(sslk_if_inst.ctrl), .bus_addr_in, .bus_wr_in,
        .bus_rd_in, .bus_wdata_in, .bus_rdata_out, .irq_out);
    sslk_proc #(.TX_BLK_GAP(200), .MS_TICK(100)) sslk_proc_inst (
        .clk_in, .reset_in, .link(sslk_if_inst.proc), .tx_valid_in, .tx_data_in,
        .tx_last_in, .tx_ready_out, .rx_word_valid_out, .rx_word_out, .block_done_out,
        .block_err_out);
    sslk_chk #(.HALF_BIT(4)) sslk_chk_inst (
        .clk_in, .reset_in, .link_clk(sslk_if_inst.link_clk),
        .c2p_envelope(sslk_if_inst.c2p_envelope), .c2p_data(sslk_if_inst.c2p_data),
        .p2c_envelope(sslk_if_inst.p2c_envelope), .p2c_data(sslk_if_inst.p2c_data));

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    function automatic logic [3:0] exp_err(input logic [15:0] len, input int n);
        if (len > MAX_LEN_WORD) return ERR_LEN_BIG;
        if (n != len + 2) return ERR_LEN_MISMATCH;
        return ERR_NONE;
    endfunction

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        bus_addr_in <= a;
        bus_wdata_in <= d;
        bus_wr_in <= 1'b1;
        @(posedge clk_in);
        bus_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_in);
        bus_addr_in <= a;
        bus_rd_in <= 1'b1;
        @(posedge clk_in);
        bus_rd_in <= 1'b0;
        #1 d = bus_rdata_out;
    endtask
    task automatic put(input logic [15:0] w);
        do rd(ADDR_STATUS_RD, v); while (v[ST_TX_ROOM] !== 1'b1);
        wr(ADDR_TX_DATA, w);
        exp_q.push_back(w);
    endtask
    task automatic blk_end(input logic [15:0] len, input int n);
        do begin @(posedge clk_in); #1; end while (block_done_out !== 1'b1);
        chk("block error", 16'(exp_err(len, n)), 16'(block_err_out));
        chk("words left", 16'h0000, 16'(exp_q.size()));
    endtask
    // Valid stays up between words; caller drops it after the last
    task automatic pw(input logic [15:0] d, input logic last);
        tx_data_in <= d;
        tx_last_in <= last;
        tx_valid_in <= 1'b1;
        do @(negedge clk_in); while (tx_ready_out !== 1'b1);
        @(posedge clk_in);
    endtask
    task automatic hread(input logic [15:0] w);
        logic [15:0] r;
        do rd(ADDR_STATUS_RD, r); while (r[ST_RX_NONE] !== 1'b0);
        rd(ADDR_RX_DATA, r);
        chk("host rx word", w, r);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(negedge clk_in) begin
        if (rx_word_valid_out === 1'b1) begin
            chk("proc rx word", exp_q.size() > 0 ? exp_q[0] : 16'hXXXX, rx_word_out);
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end

    initial begin
        repeat (40000) @(posedge clk_in);
        err_total++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        #1 chk("irq idle", 16'h0000, 16'(irq_out));
        rd(ADDR_STATUS_RD, v);
        chk("status idle", 16'h000E, v);
        rd(16'h1234, v);
        chk("unmapped read", 16'h0000, v);
        // One word goes to the shifter, four fill the buffer, the sixth is refused
        blk[0] = 16'($random(seed));
        blk[1] = 16'h0003;
        for (int i = 2; i < 6; i++) blk[i] = 16'($random(seed));
        wr(ADDR_TX_DATA, blk[0]);
        for (int i = 0; i < 5; i++) exp_q.push_back(blk[i]);
        wait (sslk_if_inst.c2p_envelope === 1'b1);
        for (int i = 1; i < 6; i++) begin
            @(posedge clk_in);
            bus_addr_in <= ADDR_TX_DATA;
            bus_wdata_in <= blk[i];
            bus_wr_in <= 1'b1;
        end
        @(posedge clk_in);
        bus_wr_in <= 1'b0;
        rd(ADDR_STATUS_RD, v);
        chk("status full", 16'h0016, v);
        blk_end(16'h0003, 5);
        for (int c = 0; c < 4; c++) begin
            put(16'($random(seed)));
            put(case_len[c]);
            for (int i = 0; i < case_pay[c]; i++) put(16'($random(seed)));
            blk_end(case_len[c], case_pay[c] + 2);
        end
        blk[0] = 16'($random(seed));
        blk[1] = 16'h0001;
        blk[2] = 16'($random(seed));
        @(posedge clk_in);
        fork
            begin
                for (int i = 0; i < 3; i++) pw(blk[i], i == 2);
                tx_valid_in <= 1'b0;
            end
            begin
                wait (irq_out === 1'b1);
                rd(ADDR_STATUS_RD, v);
                chk("status at irq", 16'h000D, v);
                for (int i = 0; i < 3; i++) hread(blk[i]);
            end
        join
        wr(ADDR_CTRL_WR, INT_CLEAR_VALUE);
        rd(ADDR_STATUS_RD, v);
        chk("irq cleared", 16'h000E, v);
        // Two unread words: the second finds the holder full
        repeat (500) @(posedge clk_in);
        blk[3] = 16'($random(seed));
        pw(blk[3], 1'b0);
        pw(16'($random(seed)), 1'b1);
        tx_valid_in <= 1'b0;
        wait (sslk_if_inst.p2c_envelope === 1'b1);
        wait (sslk_if_inst.p2c_envelope === 1'b0);
        repeat (16) @(posedge clk_in);
        wr(16'h7242, 16'h0000);
        rd(ADDR_STATUS_RD, v);
        chk("status overflow", 16'h0009, v);
        wr(ADDR_CTRL_WR, OVERRUN_CLEAR_VALUE);
        rd(ADDR_STATUS_RD, v);
        chk("overflow cleared", 16'h000D, v);
        rd(ADDR_RX_DATA, v);
        chk("kept word", blk[3], v);
        wr(ADDR_CTRL_WR, INT_CLEAR_VALUE);
        rd(ADDR_STATUS_RD, v);
        chk("link reset", 16'h000E, v);
        test_done();
    end
endmodule
